/* pkg/tdp_params.svh */
`ifndef TDP_PARAMS_SVH
`define TDP_PARAMS_SVH

// ----------------------------------------
// Reset values and pin levels
// ----------------------------------------
`define TDP_OE_OFF 1'b0
`define TDP_OE_ON 1'b1
`define TDP_LVL_LOW 1'b0
`define TDP_LVL_HIGH 1'b1
`define TDP_PINS_RST 8'h9b
`define TDP_DEF_NUM_CORES 2
`define TDP_MAX_CORES 8
`define TDP_STAT_BIT_CLK 1
`define TDP_STAT_BIT_DIN 0
`define TDP_GIO_CLK 0
`define TDP_GIO_DIN 1
`define TDP_GIO_DOUT 2

`endif

/* pkg/tdp_pkg.sv */
`default_nettype none

package tdp_pkg;

    // ----------------------------------------
    // Shared pin function and mode types
    // ----------------------------------------
    typedef enum logic [1:0] {
        TDP_FN_DEBUG = 2'h0,
        TDP_FN_STATUS = 2'h1,
        TDP_FN_GPIO = 2'h2
    } tdp_fn_t;

    typedef enum logic [1:0] {
        TDP_ST_NORMAL = 2'h1,
        TDP_ST_DEBUG = 2'h2
    } tdp_mode_t;

    // Raw pin levels, all asynchronous to clk
    typedef struct packed {
        logic int_n;
        logic scan_shift_enable;
        logic test_mode_enable;
        logic debug_request_n;
        logic sys_reset_n;
        logic debug_bit_clock;
        logic debug_serial_in;
        logic debug_serial_out;
    } tdp_pins_t;

    // Pin configuration from the core
    typedef struct packed {
        tdp_fn_t clk_fn;
        tdp_fn_t din_fn;
        logic dout_gpio;
        logic [2:0] gpio_oe;
        logic [2:0] gpio_out;
        logic [1:0] chip_status;
    } tdp_cfg_t;

    // Drive of one shared pin
    typedef struct packed {
        logic out;
        logic oe;
    } tdp_drv_t;

endpackage : tdp_pkg

`default_nettype wire

/* design/tdp_sync.sv */
`default_nettype none

module tdp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ----------------------------------------
    // Two flop synchroniser
    // ----------------------------------------
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    initial begin
        if (WIDTH < 1) begin
            $error("tdp_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule : tdp_sync

`default_nettype wire

/* design/tdp_pin_ctrl.sv */
`include "tdp_params.svh"
`default_nettype none

// How it works
// - A low on the interrupt pin reaches the core interrupt A input.
// - Scan chains shift only while scan enable and test enable are high.
// - Test enable selects the crystal input as clock of every flop.
// - A low debug request moves the block into debug mode.
// - With the clock pin an input, its edges clock debug transfers.
// - With the data-in pin an input, it is sampled on clock rises.
// - As outputs, the clock pin shows status 1, data-in status 0.
// - The serial output pin carries debug data or general I/O 2.
// - Clock pin and data-in pin may serve as general I/O 0 and 1.
// - A low system reset pin resets all processors, except in the case below.
// - Reset with debug request low in debug mode resets the target.
module tdp_pin_ctrl #(
    parameter int NUM_CORES = `TDP_DEF_NUM_CORES,
    parameter int SEL_W = (NUM_CORES > 1) ? $clog2(NUM_CORES) : 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire tdp_pkg::tdp_pins_t pins,
    input wire logic [SEL_W-1:0] debug_target_select,
    input wire tdp_pkg::tdp_cfg_t cfg,
    input wire logic dbg_tx_bit,
    input wire logic dbg_release,
    output logic core_interrupt_a_n,
    output logic scan_shift,
    output logic test_mode,
    output logic crystal_clock_sel,
    output logic debug_mode,
    output logic dbg_rx_bit,
    output logic dbg_rx_valid,
    output logic dbg_tx_take,
    output logic [2:0] general_io_in,
    output logic [NUM_CORES-1:0] proc_reset_n,
    output tdp_pkg::tdp_drv_t debug_bit_clock_drv,
    output tdp_pkg::tdp_drv_t debug_serial_in_drv,
    output tdp_pkg::tdp_drv_t debug_serial_out_drv
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        tdp_pkg::tdp_mode_t mode;
        logic dbg;
        tdp_pkg::tdp_cfg_t cfg;
        logic bclk_prev;
        logic int_n;
        logic scan;
        logic test;
        logic xtal_sel;
        logic rx_bit;
        logic rx_valid;
        logic tx_bit;
        logic tx_take;
        logic [2:0] gio_in;
        logic [NUM_CORES-1:0] proc_rst_n;
        tdp_pkg::tdp_drv_t clk_drv;
        tdp_pkg::tdp_drv_t din_drv;
        tdp_pkg::tdp_drv_t dout_drv;
    } tdp_state_t;

    localparam tdp_pkg::tdp_cfg_t CFG_RST = '{
        clk_fn: tdp_pkg::TDP_FN_DEBUG,
        din_fn: tdp_pkg::TDP_FN_DEBUG,
        dout_gpio: `TDP_LVL_LOW,
        gpio_oe: {3{`TDP_OE_OFF}},
        gpio_out: {3{`TDP_LVL_LOW}},
        chip_status: {2{`TDP_LVL_LOW}}
    };

    localparam tdp_pkg::tdp_drv_t DRV_OFF = '{
        out: `TDP_LVL_LOW,
        oe: `TDP_OE_OFF
    };

    localparam tdp_state_t ST_RST = '{
        mode: tdp_pkg::TDP_ST_NORMAL,
        dbg: `TDP_LVL_LOW,
        cfg: CFG_RST,
        bclk_prev: `TDP_LVL_LOW,
        int_n: `TDP_LVL_HIGH,
        scan: `TDP_LVL_LOW,
        test: `TDP_LVL_LOW,
        xtal_sel: `TDP_LVL_LOW,
        rx_bit: `TDP_LVL_LOW,
        rx_valid: `TDP_LVL_LOW,
        tx_bit: `TDP_LVL_LOW,
        tx_take: `TDP_LVL_LOW,
        gio_in: {3{`TDP_LVL_LOW}},
        proc_rst_n: {NUM_CORES{`TDP_LVL_LOW}},
        clk_drv: DRV_OFF,
        din_drv: DRV_OFF,
        dout_drv: DRV_OFF
    };

    initial begin
        if (NUM_CORES < 1 || NUM_CORES > `TDP_MAX_CORES) begin
            $error("tdp_pin_ctrl: NUM_CORES out of range");
        end
        if (SEL_W < 1 || (1 << SEL_W) < NUM_CORES) begin
            $error("tdp_pin_ctrl: SEL_W too narrow");
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    tdp_pkg::tdp_pins_t pins_s;
    logic [SEL_W-1:0] sel_s;

    tdp_sync #(
        .WIDTH($bits(tdp_pkg::tdp_pins_t)),
        .RST_VAL(`TDP_PINS_RST)
    ) u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(pins),
        .q(pins_s)
    );

    tdp_sync #(
        .WIDTH(SEL_W),
        .RST_VAL('0)
    ) u_sel_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(debug_target_select),
        .q(sel_s)
    );

    // ----------------------------------------
    // Shared pin drive
    // ----------------------------------------
    function automatic tdp_pkg::tdp_drv_t pin_drive(
        input tdp_pkg::tdp_fn_t fn,
        input logic status_bit,
        input logic gpio_oe,
        input logic gpio_out
    );
        tdp_pkg::tdp_drv_t d;
        d = DRV_OFF;
        unique case (fn)
            tdp_pkg::TDP_FN_STATUS: begin
                d.out = status_bit;
                d.oe = `TDP_OE_ON;
            end
            tdp_pkg::TDP_FN_GPIO: begin
                d.out = gpio_out;
                d.oe = gpio_oe;
            end
            default: begin
                d = DRV_OFF;
            end
        endcase
        return d;
    endfunction : pin_drive

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    tdp_state_t st_ff;
    tdp_state_t nxt_st;
    logic clk_is_dbg;
    logic bclk_rise;
    logic bclk_fall;
    logic in_debug;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.cfg = cfg;
        in_debug = (st_ff.mode == tdp_pkg::TDP_ST_DEBUG);
        clk_is_dbg = (st_ff.cfg.clk_fn == tdp_pkg::TDP_FN_DEBUG);
        bclk_rise = clk_is_dbg && pins_s.debug_bit_clock
            && !st_ff.bclk_prev;
        bclk_fall = clk_is_dbg && !pins_s.debug_bit_clock
            && st_ff.bclk_prev;
        nxt_st.bclk_prev = pins_s.debug_bit_clock;

        nxt_st.int_n = pins_s.int_n;
        nxt_st.test = pins_s.test_mode_enable;
        nxt_st.xtal_sel = pins_s.test_mode_enable;
        nxt_st.scan = pins_s.test_mode_enable
            && pins_s.scan_shift_enable;

        unique case (st_ff.mode)
            tdp_pkg::TDP_ST_NORMAL: begin
                if (!pins_s.debug_request_n) begin
                    nxt_st.mode = tdp_pkg::TDP_ST_DEBUG;
                end
            end
            tdp_pkg::TDP_ST_DEBUG: begin
                if (dbg_release && pins_s.debug_request_n) begin
                    nxt_st.mode = tdp_pkg::TDP_ST_NORMAL;
                end
            end
            default: begin
                nxt_st.mode = tdp_pkg::TDP_ST_NORMAL;
            end
        endcase
        nxt_st.dbg = (nxt_st.mode == tdp_pkg::TDP_ST_DEBUG);

        // Debug serial transfers
        nxt_st.rx_valid = `TDP_LVL_LOW;
        nxt_st.tx_take = `TDP_LVL_LOW;
        if (in_debug && bclk_rise
            && st_ff.cfg.din_fn == tdp_pkg::TDP_FN_DEBUG) begin
            nxt_st.rx_bit = pins_s.debug_serial_in;
            nxt_st.rx_valid = `TDP_LVL_HIGH;
        end
        if (in_debug && bclk_fall) begin
            nxt_st.tx_bit = dbg_tx_bit;
            nxt_st.tx_take = `TDP_LVL_HIGH;
        end

        // Processor resets
        nxt_st.proc_rst_n = {NUM_CORES{`TDP_LVL_HIGH}};
        if (!pins_s.sys_reset_n) begin
            if (in_debug && !pins_s.debug_request_n) begin
                for (int i = 0; i < NUM_CORES; i++) begin
                    if (sel_s == SEL_W'(i)) begin
                        nxt_st.proc_rst_n[i] = `TDP_LVL_LOW;
                    end
                end
            end else begin
                nxt_st.proc_rst_n = {NUM_CORES{`TDP_LVL_LOW}};
            end
        end

        // Pin drive and general inputs
        nxt_st.clk_drv = pin_drive(st_ff.cfg.clk_fn,
            st_ff.cfg.chip_status[`TDP_STAT_BIT_CLK],
            st_ff.cfg.gpio_oe[`TDP_GIO_CLK],
            st_ff.cfg.gpio_out[`TDP_GIO_CLK]);
        nxt_st.din_drv = pin_drive(st_ff.cfg.din_fn,
            st_ff.cfg.chip_status[`TDP_STAT_BIT_DIN],
            st_ff.cfg.gpio_oe[`TDP_GIO_DIN],
            st_ff.cfg.gpio_out[`TDP_GIO_DIN]);
        if (st_ff.cfg.dout_gpio) begin
            nxt_st.dout_drv.out = st_ff.cfg.gpio_out[`TDP_GIO_DOUT];
            nxt_st.dout_drv.oe = st_ff.cfg.gpio_oe[`TDP_GIO_DOUT];
        end else begin
            nxt_st.dout_drv.out = nxt_st.tx_bit;
            nxt_st.dout_drv.oe = (nxt_st.mode == tdp_pkg::TDP_ST_DEBUG)
                ? `TDP_OE_ON : `TDP_OE_OFF;
        end
        nxt_st.gio_in[`TDP_GIO_CLK] = pins_s.debug_bit_clock;
        nxt_st.gio_in[`TDP_GIO_DIN] = pins_s.debug_serial_in;
        nxt_st.gio_in[`TDP_GIO_DOUT] = pins_s.debug_serial_out;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign core_interrupt_a_n = st_ff.int_n;
    assign scan_shift = st_ff.scan;
    assign test_mode = st_ff.test;
    assign crystal_clock_sel = st_ff.xtal_sel;
    assign debug_mode = st_ff.dbg;
    assign dbg_rx_bit = st_ff.rx_bit;
    assign dbg_rx_valid = st_ff.rx_valid;
    assign dbg_tx_take = st_ff.tx_take;
    assign general_io_in = st_ff.gio_in;
    assign proc_reset_n = st_ff.proc_rst_n;
    assign debug_bit_clock_drv = st_ff.clk_drv;
    assign debug_serial_in_drv = st_ff.din_drv;
    assign debug_serial_out_drv = st_ff.dout_drv;

endmodule : tdp_pin_ctrl

`default_nettype wire

/* verif/tdp_dbg_host.sv */
`default_nettype none

module tdp_dbg_host (
    output logic dck,
    output logic dat
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------
    // Debug host
    // ----------
    initial begin
        dck = 1'b0;
        dat = 1'b1;
    end

    task automatic xfer(input logic b);
        #7 dat = b;
        #200 dck = 1'b1;
        #200 dck = 1'b0;
        #20 dat = ~b;
    endtask : xfer
endmodule : tdp_dbg_host

`default_nettype wire

/* verif/tdp_pin_ctrl_checker.sv */
`default_nettype none

module tdp_pin_ctrl_checker #(
    parameter int NUM_CORES = 2,
    parameter int SEL_W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire tdp_pkg::tdp_pins_t pins,
    input wire tdp_pkg::tdp_cfg_t cfg,
    input wire logic dbg_tx_bit,
    input wire logic core_interrupt_a_n,
    input wire logic scan_shift,
    input wire logic test_mode,
    input wire logic crystal_clock_sel,
    input wire logic debug_mode,
    input wire logic dbg_rx_bit,
    input wire logic dbg_rx_valid,
    input wire logic dbg_tx_take,
    input wire logic [NUM_CORES-1:0] proc_reset_n,
    input wire tdp_pkg::tdp_drv_t debug_bit_clock_drv,
    input wire tdp_pkg::tdp_drv_t debug_serial_in_drv,
    input wire tdp_pkg::tdp_drv_t debug_serial_out_drv
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------
    // Checks
    // ------
    logic [1:0] up_ff;
    logic up;
    assign up = (up_ff == 2'h3);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            up_ff <= 2'h0;
        end else if (!up) begin
            up_ff <= up_ff + 2'h1;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    irq_follow_a: assert property (
        up |-> core_interrupt_a_n == $past(pins.int_n, 3))
        else $error("irq level wrong");
    scan_gate_a: assert property (
        up |-> scan_shift == ($past(pins.scan_shift_enable, 3)
            && $past(pins.test_mode_enable, 3)))
        else $error("scan shift wrong");
    test_clk_a: assert property (
        up |-> test_mode == $past(pins.test_mode_enable, 3)
            && crystal_clock_sel == test_mode)
        else $error("test clock wrong");
    dbg_entry_a: assert property (
        up && !$past(pins.debug_request_n, 3) |-> debug_mode)
        else $error("no debug entry");
    rx_pulse_a: assert property (
        dbg_rx_valid |-> dbg_rx_bit == $past(pins.debug_serial_in, 3)
            ##1 !dbg_rx_valid)
        else $error("rx bit wrong");
    stat_pins_a: assert property (
        up && $past(cfg.clk_fn, 2) == tdp_pkg::TDP_FN_STATUS
        |-> debug_bit_clock_drv == {$past(cfg.chip_status[1], 2), 1'h1})
        else $error("status pin wrong");
    tx_out_a: assert property (
        dbg_tx_take && !$past(cfg.dout_gpio, 2)
        |-> debug_serial_out_drv.out == $past(dbg_tx_bit))
        else $error("tx bit wrong");
    gpio_din_a: assert property (
        up && $past(cfg.din_fn, 2) == tdp_pkg::TDP_FN_GPIO |->
        debug_serial_in_drv ==
            {$past(cfg.gpio_out[1], 2), $past(cfg.gpio_oe[1], 2)})
        else $error("gpio pin wrong");
    rst_all_a: assert property (
        up && !$past(pins.sys_reset_n, 3)
        && $past(pins.debug_request_n, 3) |-> proc_reset_n == '0)
        else $error("cores not reset");
    rst_io_a: assert property (
        up_ff < 2'h2 |-> !debug_bit_clock_drv.oe
            && !debug_serial_in_drv.oe && !debug_serial_out_drv.oe)
        else $error("pin driven at reset");
endmodule : tdp_pin_ctrl_checker

bind tdp_pin_ctrl tdp_pin_ctrl_checker #(
    .NUM_CORES(NUM_CORES),
    .SEL_W(SEL_W)
) i_chk (
    .clk(clk), .rst_b(rst_b), .pins(pins), .cfg(cfg),
    .dbg_tx_bit(dbg_tx_bit), .core_interrupt_a_n(core_interrupt_a_n),
    .scan_shift(scan_shift), .test_mode(test_mode),
    .crystal_clock_sel(crystal_clock_sel), .debug_mode(debug_mode),
    .dbg_rx_bit(dbg_rx_bit), .dbg_rx_valid(dbg_rx_valid),
    .dbg_tx_take(dbg_tx_take), .proc_reset_n(proc_reset_n),
    .debug_bit_clock_drv(debug_bit_clock_drv),
    .debug_serial_in_drv(debug_serial_in_drv),
    .debug_serial_out_drv(debug_serial_out_drv)
);

`default_nettype wire

/* verif/test_test_debug_pin_control.sv */
`default_nettype none

module test_test_debug_pin_control;
    timeunit 1ns;
    timeprecision 1ps;

    // -----
    // Bench
    // -----
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] pv = 8'h9f;
    logic [0:0] sel = 1'h0;
    tdp_pkg::tdp_cfg_t cfg = '0;
    logic tx_bit = 1'b0;
    logic rel = 1'b0;
    tdp_pkg::tdp_pins_t pins;
    logic irq_n, scan, tst, xsel, dmode, rx_bit, rx_v, tx_take;
    logic [2:0] gio;
    logic [1:0] prst_n;
    tdp_pkg::tdp_drv_t ck_d, di_d, do_d;
    logic hck, hdi, rx_last, tx_seen;
    int bad_count = 0;
    int samples_checked = 0;
    int n_take = 0;

    always #25 clk = ~clk;
    assign pins = {pv[7:3], ck_d.oe ? ck_d.out : hck,
        di_d.oe ? di_d.out : hdi, do_d.oe ? do_d.out : pv[0]};

    tdp_pin_ctrl i_dut (
        .clk(clk), .rst_b(rst_b), .pins(pins),
        .debug_target_select(sel), .cfg(cfg), .dbg_tx_bit(tx_bit),
        .dbg_release(rel), .core_interrupt_a_n(irq_n),
        .scan_shift(scan), .test_mode(tst), .crystal_clock_sel(xsel),
        .debug_mode(dmode), .dbg_rx_bit(rx_bit), .dbg_rx_valid(rx_v),
        .dbg_tx_take(tx_take), .general_io_in(gio), .proc_reset_n(prst_n),
        .debug_bit_clock_drv(ck_d), .debug_serial_in_drv(di_d),
        .debug_serial_out_drv(do_d)
    );
    tdp_dbg_host i_host (.dck(hck), .dat(hdi));

    always @(posedge clk) begin
        if (rx_v) begin
            rx_last <= rx_bit;
        end
        if (tx_take) begin
            n_take <= n_take + 1;
            tx_seen <= do_d.out;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic t_levels;
        for (int i = 0; i < 8; i++) begin
            pv[7:5] = i[2:0];
            tick(4);
            chk({4'h0, irq_n, scan, tst, xsel},
                {4'h0, i[2], i[1] & i[0], i[0], i[0]});
        end
        pv[7:5] = 3'h4;
    endtask : t_levels

    task automatic t_pinfn;
        cfg.chip_status = 2'h2;
        cfg.gpio_oe = 3'h5;
        cfg.gpio_out = 3'h3;
        cfg.clk_fn = tdp_pkg::TDP_FN_STATUS;
        cfg.din_fn = tdp_pkg::TDP_FN_STATUS;
        tick(3);
        chk({4'h0, ck_d, di_d}, 8'h0d);
        cfg.clk_fn = tdp_pkg::TDP_FN_GPIO;
        cfg.din_fn = tdp_pkg::TDP_FN_GPIO;
        cfg.dout_gpio = 1'b1;
        tick(5);
        chk({2'h0, ck_d, di_d, do_d}, 8'h39);
        chk({5'h0, gio}, 8'h03);
        cfg = '0;
        tick(5);
    endtask : t_pinfn

    task automatic t_debug;
        pv[4] = 1'b0;
        tick(4);
        chk({6'h0, dmode, do_d.oe}, 8'h03);
        for (int i = 0; i < 2; i++) begin
            tx_bit = i[0];
            i_host.xfer(~i[0]);
            tick(4);
            chk({6'h0, rx_last, tx_seen}, {6'h0, ~i[0], i[0]});
        end
        chk(n_take[7:0], 8'h02);
    endtask : t_debug

    task automatic t_rst;
        sel = 1'h1;
        pv[3] = 1'b0;
        tick(4);
        chk({6'h0, prst_n}, 8'h01);
        pv[4:3] = 2'h3;
        rel = 1'b1;
        tick(4);
        chk({5'h0, prst_n, dmode}, 8'h06);
        rel = 1'b0;
        pv[3] = 1'b0;
        tick(4);
        chk({6'h0, prst_n}, 8'h00);
        pv[3] = 1'b1;
    endtask : t_rst

    initial begin
        tick(5);
        chk({3'h0, ck_d.oe, di_d.oe, do_d.oe, prst_n}, 8'h00);
        rst_b = 1'b1;
        tick(4);
        t_levels();
        t_pinfn();
        t_debug();
        t_rst();
        close_out();
    end

    initial begin
        #200us;
        bad_count++;
        close_out();
    end
endmodule : test_test_debug_pin_control

`default_nettype wire
